// ===== rtl/uart_ctrl_pkg.sv
package uart_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register map, printed per channel
  // ----------------------------------------------------------------
  localparam logic [31:0] CHAN_CTRL_CH0  = 32'h5000_0004;
  localparam logic [31:0] CHAN_CTRL_CH1  = 32'h5000_4004;
  localparam logic [31:0] CHAN_CTRL_CH2  = 32'h5000_8004;
  localparam logic [31:0] FIFO_CTRL_CH0  = 32'h0500_0008;
  localparam logic [31:0] FIFO_CTRL_CH1  = 32'h5000_4008;
  localparam logic [31:0] FIFO_CTRL_CH2  = 32'h5000_8008;
  localparam logic [31:0] MODEM_CTRL_CH0 = 32'h5000_000c;
  localparam logic [31:0] MODEM_CTRL_CH1 = 32'h5000_400c;
  localparam logic [31:0] STATUS_CH0     = 32'h5000_0010;
  localparam logic [31:0] STATUS_CH1     = 32'h5000_4010;
  localparam logic [31:0] STATUS_CH2     = 32'h5000_8010;
  localparam logic [31:0] FIFO_STAT_CH0  = 32'h5000_0018;
  localparam logic [31:0] FIFO_STAT_CH1  = 32'h5000_4018;
  localparam logic [31:0] FIFO_STAT_CH2  = 32'h5000_8018;
  localparam logic [31:0] TX_BUF_CH0     = 32'h5000_0020;
  localparam logic [31:0] TX_BUF_CH1     = 32'h5000_4020;
  localparam logic [31:0] TX_BUF_CH2     = 32'h5000_8020;
  localparam logic [31:0] RX_BUF_CH0     = 32'h5000_0024;
  localparam logic [31:0] RX_BUF_CH1     = 32'h5000_4024;
  localparam logic [31:0] RX_BUF_CH2     = 32'h5000_8024;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int          CC_RX_MODE_LSB  = 0;
  localparam int          CC_TX_MODE_LSB  = 2;
  localparam int          CC_TIMEOUT_BIT  = 7;
  localparam int          CC_WIDTH        = 11;
  localparam int          MC_AFC_BIT      = 4;
  localparam int          MC_RTS_BIT      = 0;
  localparam int          FS_TX_CNT_LSB   = 8;
  localparam int          FS_TX_FULL_BIT  = 14;
  localparam int          FS_RX_FULL_BIT  = 6;
  localparam int          FS_CNT_W        = 6;
  localparam logic [10:0] CHAN_CTRL_RESET = 11'h000;
  localparam logic [7:0]  FIFO_CTRL_RESET = 8'h00;
  localparam logic [7:0]  MODEM_RESET     = 8'h00;

  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_CPU   = 2'h1;
  localparam logic [1:0] MODE_DMA_A = 2'h2;
  localparam logic [1:0] MODE_DMA_B = 2'h3;

  localparam logic [6:0] TX_LVL_0 = 7'h00;
  localparam logic [6:0] TX_LVL_1 = 7'h10;
  localparam logic [6:0] TX_LVL_2 = 7'h20;
  localparam logic [6:0] TX_LVL_3 = 7'h30;
  localparam logic [6:0] RX_LVL_0 = 7'h01;
  localparam logic [6:0] RX_LVL_1 = 7'h08;
  localparam logic [6:0] RX_LVL_2 = 7'h10;
  localparam logic [6:0] RX_LVL_3 = 7'h20;

  // ----------------------------------------------------------------
  // Receive time-out
  // ----------------------------------------------------------------
  localparam logic [5:0] TIMEOUT_WORDS = 6'h03;
  localparam logic [3:0] FIXED_BITS    = 4'h7;

  typedef struct packed {
    logic [1:0] tx_trig;
    logic [1:0] rx_trig;
    logic       rsvd;
    logic       tx_rst;
    logic       rx_rst;
    logic       en;
  } fifo_ctrl_t;

  typedef struct packed {
    logic       two_stop;
    logic       parity_on;
    logic [1:0] word_len;
  } frame_fmt_t;

  typedef enum logic [1:0] {
    TO_IDLE  = 2'b00,
    TO_COUNT = 2'b01,
    TO_FIRED = 2'b10
  } timeout_state_t;

endpackage

// ===== rtl/uart_fifo_flow_status_ctrl.sv
// Summary of operation
// - Transmit mode 00 stops sending, 01 CPU requests, else DMA refills.
// - Receive mode 00 stops receiving, 01 CPU requests, else DMA drains.
// - Code 10: DMA0 on channel 0, DMA3 on channel 2; 11: DMA1, channel 1.
// - DMA receive with FIFO: three idle word times below trigger raise request.
// - Transmit trigger codes give empty, 16, 32, 48 bytes.
// - Receive trigger codes give 1, 8, 16, 32 bytes.
// - Auto flow control drives request-to-send itself, ignoring software bit.
// - Without auto flow, software bit 1 drives pin low, 0 high.
// - Channel 2 has no modem control register and no auto flow.
// - Buffer-empty flag follows empty buffer; requests service in non-FIFO mode.
// - In FIFO mode trigger code 00 requests service only when empty, others at or below level.
// - Data-ready flag follows valid receive data; requests service without FIFO.
// - FIFO status: transmit count 13:8, receive count 5:0, full flags.
// - Time-out needs its enable bit and FIFO enabled; acts as receive request.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps

module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             flush,
  input  wire logic             single,
  input  wire logic             in_valid,
  output      logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             out_valid,
  input  wire logic             out_ready,
  output      logic [WIDTH-1:0] out_data,
  output      logic [CW-1:0]    count
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             push;
  logic             pop;

  // Single-register operation caps the store at one word
  always_comb begin
    in_ready    = single ? (count == '0) : (count != CW'(DEPTH));
    out_valid   = (count != '0);
    out_data    = mem[rd_ptr];
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end else begin
      if (push) next_wr_ptr = wr_ptr + 1'b1;
      if (pop) next_rd_ptr = rd_ptr + 1'b1;
      next_count = count + CW'(push) - CW'(pop);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage carries no reset, it is guarded by count
  always_ff @(posedge sys_clk) begin
    if (push && !flush) mem[wr_ptr] <= in_data;
  end
endmodule

module uart_fifo_flow_status_ctrl
  import uart_ctrl_pkg::*;
#(
  parameter int CHANNEL = 0,
  parameter int DEPTH   = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output      logic [31:0] rdata,
  output      logic [7:0]  tx_data,
  output      logic        tx_valid,
  input  wire logic        tx_ready,
  input  wire logic        tx_shift_busy,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_valid,
  output      logic        rx_ready,
  input  wire logic        bit_tick,
  input  wire frame_fmt_t  frame_fmt,
  input  wire logic        clear_to_send_pin_n,
  output      logic        send_request_pin_n,
  output      logic        tx_req,
  output      logic        rx_req,
  output      logic [3:0]  dma_req
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam bit HAS_MODEM = (CHANNEL != 2);
  localparam logic [31:0] A_CC = (CHANNEL == 0) ? CHAN_CTRL_CH0 :
                                 (CHANNEL == 1) ? CHAN_CTRL_CH1 : CHAN_CTRL_CH2;
  localparam logic [31:0] A_FC = (CHANNEL == 0) ? FIFO_CTRL_CH0 :
                                 (CHANNEL == 1) ? FIFO_CTRL_CH1 : FIFO_CTRL_CH2;
  localparam logic [31:0] A_MC = (CHANNEL == 0) ? MODEM_CTRL_CH0 :
                                 MODEM_CTRL_CH1;
  localparam logic [31:0] A_ST = (CHANNEL == 0) ? STATUS_CH0 :
                                 (CHANNEL == 1) ? STATUS_CH1 : STATUS_CH2;
  localparam logic [31:0] A_FS = (CHANNEL == 0) ? FIFO_STAT_CH0 :
                                 (CHANNEL == 1) ? FIFO_STAT_CH1 : FIFO_STAT_CH2;
  localparam logic [31:0] A_TB = (CHANNEL == 0) ? TX_BUF_CH0 :
                                 (CHANNEL == 1) ? TX_BUF_CH1 : TX_BUF_CH2;
  localparam logic [31:0] A_RB = (CHANNEL == 0) ? RX_BUF_CH0 :
                                 (CHANNEL == 1) ? RX_BUF_CH1 : RX_BUF_CH2;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [6:0] tx_level(input logic [1:0] code);
    case (code)
      2'h0:    tx_level = TX_LVL_0;
      2'h1:    tx_level = TX_LVL_1;
      2'h2:    tx_level = TX_LVL_2;
      default: tx_level = TX_LVL_3;
    endcase
  endfunction

  function automatic logic [6:0] rx_level(input logic [1:0] code);
    case (code)
      2'h0:    rx_level = RX_LVL_0;
      2'h1:    rx_level = RX_LVL_1;
      2'h2:    rx_level = RX_LVL_2;
      default: rx_level = RX_LVL_3;
    endcase
  endfunction

  // Each channel owns one request line, for one DMA code only
  function automatic logic [3:0] dma_route(input logic [1:0] mode);
    dma_route = 4'h0;
    if (mode == MODE_DMA_A && CHANNEL == 0) dma_route = 4'h1;
    if (mode == MODE_DMA_A && CHANNEL == 2) dma_route = 4'h8;
    if (mode == MODE_DMA_B && CHANNEL == 1) dma_route = 4'h2;
  endfunction

  // ----------------------------------------------------------------
  // Registers and buffers
  // ----------------------------------------------------------------
  logic [10:0]    chan_ctrl;
  fifo_ctrl_t     fifo_ctrl;
  logic [7:0]     modem_ctrl;
  logic [10:0]    next_chan_ctrl;
  fifo_ctrl_t     next_fifo_ctrl;
  logic [7:0]     next_modem_ctrl;
  logic [31:0]    next_rdata;
  logic [1:0]     tx_mode;
  logic [1:0]     rx_mode;
  logic           afc;
  logic           cts_ok;
  logic           tx_in_ready;
  logic           tx_fifo_valid;
  logic           rx_fifo_valid;
  logic [7:0]     rx_fifo_data;
  logic [CW-1:0]  tx_cnt;
  logic [CW-1:0]  rx_cnt;
  logic           tx_push;
  logic           rx_pop;
  logic           rx_push;
  logic           tx_full;
  logic           rx_full;

  assign tx_mode = chan_ctrl[CC_TX_MODE_LSB +: 2];
  assign rx_mode = chan_ctrl[CC_RX_MODE_LSB +: 2];
  assign afc     = HAS_MODEM && modem_ctrl[MC_AFC_BIT];
  assign cts_ok  = !afc || !clear_to_send_pin_n;
  assign tx_push = wr_en && addr == A_TB && tx_mode != MODE_OFF;
  assign rx_pop  = rd_en && addr == A_RB;
  assign rx_push = rx_valid && rx_ready && rx_mode != MODE_OFF;
  assign tx_full = fifo_ctrl.en ? (tx_cnt == CW'(DEPTH)) : (tx_cnt != '0);
  assign rx_full = fifo_ctrl.en ? (rx_cnt == CW'(DEPTH)) : (rx_cnt != '0);

  // Shifter sees nothing while disabled or held off by the peer
  sync_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .flush     (fifo_ctrl.tx_rst),
    .single    (!fifo_ctrl.en),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (wdata[7:0]),
    .out_valid (tx_fifo_valid),
    .out_ready (tx_ready && tx_mode != MODE_OFF && cts_ok),
    .out_data  (tx_data),
    .count     (tx_cnt)
  );
  assign tx_valid = tx_fifo_valid && tx_mode != MODE_OFF && cts_ok;

  sync_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .flush     (fifo_ctrl.rx_rst),
    .single    (!fifo_ctrl.en),
    .in_valid  (rx_valid && rx_mode != MODE_OFF),
    .in_ready  (rx_ready),
    .in_data   (rx_data),
    .out_valid (rx_fifo_valid),
    .out_ready (rx_pop),
    .out_data  (rx_fifo_data),
    .count     (rx_cnt)
  );

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  always_comb begin
    next_chan_ctrl  = chan_ctrl;
    next_fifo_ctrl  = fifo_ctrl;
    next_modem_ctrl = modem_ctrl;
    next_rdata      = 32'h0000_0000;
    // Reset bits live one cycle, long enough to flush
    next_fifo_ctrl.tx_rst = 1'b0;
    next_fifo_ctrl.rx_rst = 1'b0;
    if (wr_en && addr == A_CC) next_chan_ctrl = wdata[CC_WIDTH-1:0];
    if (wr_en && addr == A_FC) begin
      next_fifo_ctrl      = fifo_ctrl_t'(wdata[7:0]);
      next_fifo_ctrl.rsvd = 1'b0;
    end
    if (wr_en && addr == A_MC && HAS_MODEM) begin
      // Reserved bits are the writer's duty; kept as written
      next_modem_ctrl = wdata[7:0];
    end
    if (rd_en) begin
      case (addr)
        A_CC:    next_rdata = {21'h0, chan_ctrl};
        A_FC:    next_rdata = {24'h0, fifo_ctrl};
        A_MC:    next_rdata = HAS_MODEM ? {24'h0, modem_ctrl} : 32'h0;
        A_ST:    next_rdata = {29'h0,
                               tx_cnt == '0 && !tx_shift_busy,
                               tx_cnt == '0,
                               rx_cnt != '0};
        A_FS:    begin
          next_rdata[FS_TX_FULL_BIT] = tx_full;
          next_rdata[FS_TX_CNT_LSB +: FS_CNT_W] = FS_CNT_W'(tx_cnt);
          next_rdata[FS_RX_FULL_BIT] = rx_full;
          next_rdata[FS_CNT_W-1:0] = FS_CNT_W'(rx_cnt);
        end
        A_RB:    next_rdata = {24'h0, rx_fifo_valid ? rx_fifo_data : 8'h00};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      chan_ctrl  <= CHAN_CTRL_RESET;
      fifo_ctrl  <= fifo_ctrl_t'(FIFO_CTRL_RESET);
      modem_ctrl <= MODEM_RESET;
      rdata      <= 32'h0000_0000;
    end else begin
      chan_ctrl  <= next_chan_ctrl;
      fifo_ctrl  <= next_fifo_ctrl;
      modem_ctrl <= next_modem_ctrl;
      rdata      <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Receive time-out
  // ----------------------------------------------------------------
  timeout_state_t to_state;
  timeout_state_t next_to_state;
  logic [5:0]     to_cnt;
  logic [5:0]     next_to_cnt;
  logic [5:0]     to_limit;
  logic           to_armed;

  // Frame = start + data + parity + stop bits, three frames in a row
  assign to_limit = TIMEOUT_WORDS * 6'(FIXED_BITS
                    + 4'(frame_fmt.word_len) + 4'(frame_fmt.parity_on)
                    + 4'(frame_fmt.two_stop));
  assign to_armed = rx_mode[1] && fifo_ctrl.en
                    && chan_ctrl[CC_TIMEOUT_BIT]
                    && rx_cnt != '0
                    && 7'(rx_cnt) < rx_level(fifo_ctrl.rx_trig);

  always_comb begin
    next_to_state = to_state;
    next_to_cnt   = to_cnt;
    case (to_state)
      TO_IDLE: begin
        next_to_cnt = 6'h00;
        if (to_armed) next_to_state = TO_COUNT;
      end
      TO_COUNT: begin
        if (!to_armed || rx_push || rx_pop) begin
          next_to_state = to_armed ? TO_COUNT : TO_IDLE;
          next_to_cnt   = 6'h00;
        end else if (bit_tick) begin
          next_to_cnt = to_cnt + 6'h01;
          if (to_cnt + 6'h01 >= to_limit) next_to_state = TO_FIRED;
        end
      end
      TO_FIRED: begin
        if (rx_push || rx_pop || !to_armed) begin
          next_to_state = TO_IDLE;
          next_to_cnt   = 6'h00;
        end
      end
      default: begin
        next_to_state = TO_IDLE;
        next_to_cnt   = 6'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      to_state <= TO_IDLE;
      to_cnt   <= 6'h00;
    end else begin
      to_state <= next_to_state;
      to_cnt   <= next_to_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Requests and flow control
  // ----------------------------------------------------------------
  logic tx_cond;
  logic rx_cond;
  logic next_rts_n;

  always_comb begin
    if (!fifo_ctrl.en) begin
      tx_cond = (tx_cnt == '0);
      rx_cond = (rx_cnt != '0);
    end else begin
      tx_cond = (fifo_ctrl.tx_trig == 2'h0) ? (tx_cnt == '0) :
                (7'(tx_cnt) <= tx_level(fifo_ctrl.tx_trig));
      rx_cond = (7'(rx_cnt) >= rx_level(fifo_ctrl.rx_trig));
    end
    // Auto mode holds the peer off once one slot is left
    if (!HAS_MODEM) next_rts_n = 1'b1;
    else if (afc) next_rts_n = (7'(rx_cnt) >= 7'(DEPTH - 1));
    else next_rts_n = !modem_ctrl[MC_RTS_BIT];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tx_req             <= 1'b0;
      rx_req             <= 1'b0;
      dma_req            <= 4'h0;
      send_request_pin_n <= 1'b1;
    end else begin
      tx_req  <= tx_mode == MODE_CPU && tx_cond;
      // Time-out is a CPU request even in DMA mode, to drain the rest
      rx_req  <= (rx_mode == MODE_CPU && rx_cond)
               || to_state == TO_FIRED;
      dma_req <= (tx_cond ? dma_route(tx_mode) : 4'h0)
               | (rx_cond ? dma_route(rx_mode) : 4'h0);
      send_request_pin_n <= next_rts_n;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence flush_req_s;
    wr_en && addr == A_FC && wdata[2];
  endsequence
  sequence flush_done_s;
    fifo_ctrl.tx_rst ##1 (!fifo_ctrl.tx_rst && tx_cnt == '0);
  endsequence

  tx_flush_a: assert property (flush_req_s |=> flush_done_s)
    else $error("tx flush did not empty and self-clear");
  sw_rts_a: assert property (
    HAS_MODEM && !$past(afc) |->
      send_request_pin_n == !$past(modem_ctrl[MC_RTS_BIT]))
    else $error("software rts not reflected on pin");
  auto_rts_a: assert property (
    $past(afc) && $past(rx_cnt) == CW'(DEPTH) |-> send_request_pin_n)
    else $error("auto rts active with full receive buffer");
  no_modem_a: assert property (!HAS_MODEM |-> send_request_pin_n)
    else $error("channel without modem drove rts");
  tx_off_a: assert property (tx_mode == MODE_OFF |-> !tx_valid)
    else $error("transmit disabled but data offered");
  rx_off_a: assert property (
    rx_mode == MODE_OFF |=> !rx_req && rx_cnt <= $past(rx_cnt))
    else $error("receive disabled but active");
  tx_empty_req_a: assert property (
    tx_mode == MODE_CPU && !fifo_ctrl.en && tx_cnt == '0 |=> tx_req)
    else $error("empty buffer did not request service");
  timeout_a: assert property (
    to_state == TO_COUNT && to_armed && bit_tick && !rx_push && !rx_pop
    && to_cnt + 6'h01 >= to_limit |=> to_state == TO_FIRED)
    else $error("receive time-out not raised");
  timeout_req_a: assert property (
    to_state == TO_FIRED |=> rx_req)
    else $error("time-out did not raise receive request");
  read_once_a: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data stood beyond its cycle");
endmodule

// ===== verif/serial_peer.sv
`timescale 1ns/1ps
// ----------------------
// Far serial end
// ----------------------
module serial_peer (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       stall,
  input  wire logic [7:0] base,
  input  wire logic [5:0] to_send,
  input  wire logic       tx_valid,
  output      logic       tx_ready,
  output      logic       tx_shift_busy,
  output      logic [7:0] rx_data,
  output      logic       rx_valid,
  input  wire logic       rx_ready,
  input  wire logic       send_request_pin_n,
  output      logic       clear_to_send_pin_n
);
  logic [5:0] sent;
  logic [2:0] hold;
  logic [7:0] cur;
  assign cur                 = base + 8'(sent);
  assign clear_to_send_pin_n = stall;
  assign tx_ready            = !stall && hold == 3'h0;
  assign tx_shift_busy       = hold != 3'h0;
  assign rx_valid = sent < to_send && !send_request_pin_n;
  // Idle line inverted, so a stale byte never passes
  assign rx_data             = rx_valid ? cur : ~cur;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sent <= 6'h00;
      hold <= 3'h0;
    end else begin
      if (rx_valid && rx_ready)
        sent <= sent + 6'h01;
      if (tx_valid && tx_ready)
        hold <= 3'h4;
      else if (hold != 3'h0)
        hold <= hold - 3'h1;
    end
  end
endmodule

// ===== verif/uart_fifo_flow_status_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  n_fail++; $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module uart_fifo_flow_status_ctrl_tb;
  import uart_ctrl_pkg::*;
  // ----------------------
  // Signals
  // ----------------------
  logic        sys_clk, nrst, wr_en, rd_en, rd_d, stall, bit_tick;
  logic        tx_valid, tx_ready, tx_shift_busy, rx_valid, rx_ready;
  logic        clear_to_send_pin_n, send_request_pin_n, tx_req, rx_req;
  logic [31:0] addr, wdata, rdata, ex;
  logic [7:0]  tx_data, rx_data, base;
  logic [5:0]  to_send;
  logic [3:0]  dma_req;
  frame_fmt_t  frame_fmt;
  int          n_fail, total_checks, seed, tout;
  logic [31:0] exp_q[$];
  logic [7:0]  tx_q[$];
  uart_fifo_flow_status_ctrl #(.CHANNEL(0), .DEPTH(16))
    i_uart_fifo_flow_status_ctrl (.sys_clk, .nrst, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .tx_data, .tx_valid, .tx_ready, .tx_shift_busy,
    .rx_data, .rx_valid, .rx_ready, .bit_tick, .frame_fmt,
    .clear_to_send_pin_n, .send_request_pin_n, .tx_req, .rx_req, .dma_req);
  serial_peer i_serial_peer (.sys_clk, .nrst, .stall, .base, .to_send,
    .tx_valid, .tx_ready, .tx_shift_busy, .rx_data, .rx_valid, .rx_ready,
    .send_request_pin_n, .clear_to_send_pin_n);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // ----------------------
  // Bus tasks
  // ----------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    rd_en <= 1'b1;
    addr  <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    rd_en <= 1'b0;
  endtask
  task automatic put_tx();
    tx_q.push_back(8'($random(seed)));
    wr(TX_BUF_CH0, 32'(tx_q[$]));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Read data stand only in the cycle after the strobe
  always @(negedge sys_clk) begin
    if (rd_d) begin
      ex = exp_q.pop_front();
      `CHK("rdata", ex, rdata)
    end
    if (tx_valid && tx_ready && tx_q.size() > 0) begin
      ex = 32'(tx_q.pop_front());
      `CHK("tx_data", ex[7:0], tx_data)
    end
    rd_d = rd_en;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    report_and_stop();
  end
  // ----------------------
  // Scenarios
  // ----------------------
  initial begin
    seed = 6;
    {nrst, wr_en, rd_en, rd_d, stall, bit_tick} = 6'h00;
    {n_fail, total_checks, addr, wdata, to_send} = '0;
    base      = 8'($random(seed));
    frame_fmt = frame_fmt_t'($random(seed));
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd(STATUS_CH0, 32'h6);
    rd(FIFO_STAT_CH0, 32'h0);
    rd(MODEM_CTRL_CH0, 32'h0);
    rd(32'h5000_800c, 32'h0);
    `CHK("rts_n", 1'b1, send_request_pin_n)
    for (int m = 0; m < 4; m++) begin
      wr(CHAN_CTRL_CH0, 32'(m << 2));
      tick(2);
      `CHK("tx_req", m == 1, tx_req)
      `CHK("dma_req", 4'(m == 2), dma_req)
    end
    wr(MODEM_CTRL_CH0, 32'h1);
    tick(2);
    `CHK("rts_n", 1'b0, send_request_pin_n)
    for (int m = 1; m < 4; m++) begin
      wr(CHAN_CTRL_CH0, 32'(m));
      to_send <= to_send + 6'h1;
      tick(4);
      `CHK("rx_req", m == 1, rx_req)
      `CHK("dma_req", 4'(m == 2), dma_req)
      rd(STATUS_CH0, 32'h7);
      rd(RX_BUF_CH0, 32'(8'(base + 8'(m - 1))));
    end
    wr(CHAN_CTRL_CH0, 32'h4);
    stall <= 1'b1;
    put_tx();
    tick(2);
    `CHK("tx_req", 1'b0, tx_req)
    rd(STATUS_CH0, 32'h0);
    @(posedge sys_clk) stall <= 1'b0;
    rd(STATUS_CH0, 32'h2);
    tick(8);
    `CHK("tx_req", 1'b1, tx_req)
    wr(CHAN_CTRL_CH0, 32'h5);
    wr(FIFO_CTRL_CH0, 32'h1);
    stall   <= 1'b1;
    to_send <= to_send + 6'h8;
    put_tx();
    tick(20);
    rd(FIFO_STAT_CH0, 32'h0108);
    for (int t = 0; t < 4; t++) begin
      wr(FIFO_CTRL_CH0, 32'(t * 8'h50 + 1));
      tick(2);
      `CHK("tx_req", t != 0, tx_req)
      `CHK("rx_req", t < 2, rx_req)
    end
    wr(MODEM_CTRL_CH0, 32'h10);
    to_send <= to_send + 6'h7;
    tick(2);
    `CHK("rts_n", 1'b0, send_request_pin_n)
    `CHK("tx_valid", 1'b0, tx_valid)
    tick(20);
    `CHK("rts_n", 1'b1, send_request_pin_n)
    rd(FIFO_STAT_CH0, 32'h010f);
    wr(FIFO_CTRL_CH0, 32'h1f);
    tx_q.delete();
    rd(FIFO_STAT_CH0, 32'h0);
    rd(FIFO_CTRL_CH0, 32'h11);
    stall <= 1'b0;
    tick(2);
    `CHK("rts_n", 1'b0, send_request_pin_n)
    // Timer runs only on bit ticks, so hold them off until armed
    wr(CHAN_CTRL_CH0, 32'h82);
    to_send <= to_send + 6'h1;
    tick(6);
    tout = 3 * (7 + frame_fmt.word_len + frame_fmt.parity_on
      + frame_fmt.two_stop);
    @(posedge sys_clk) bit_tick <= 1'b1;
    tick(tout - 3);
    `CHK("dma_req", 4'h0, dma_req)
    `CHK("rx_req", 1'b0, rx_req)
    tick(6);
    `CHK("rx_req", 1'b1, rx_req)
    `CHK("dma_req", 4'h0, dma_req)
    report_and_stop();
  end
endmodule
